// ===== rtl/pixser_pkg.sv
// shared constants, modes and decode helpers of the pixel serializer
// assumes one 20 MHz system clock and a word-aligned AXI4-Lite register map
`default_nettype none
package pixser_pkg;
    localparam int unsigned WORD_BITS     = 30;        // serial word length
    localparam int unsigned COLOUR_BITS   = 24;        // colour bits per pixel
    localparam int unsigned POS_VS        = 24;        // vertical sync position
    localparam int unsigned POS_HS        = 25;        // horizontal sync position
    localparam int unsigned POS_DE        = 26;        // pixel valid position
    localparam int unsigned POS_PARITY    = 27;        // odd parity position
    localparam int unsigned POS_RSV       = 28;        // two reserved bits, low
    localparam logic [7:0]  OFS_CTRL      = 8'h00;     // idle timeout register
    localparam logic [7:0]  OFS_STATUS    = 8'h04;     // mode, lanes, lock
    localparam logic [7:0]  OFS_WORDS     = 8'h08;     // words sent counter
    localparam logic [15:0] CTRL_TIMEOUT_RST = 16'h0100; // idle cycles to standby
    localparam int unsigned STAT_LANES_LSB = 3;        // lane count field
    localparam int unsigned STAT_LOCK_BIT  = 5;        // pll locked flag
    localparam logic [1:0]  RESP_OKAY     = 2'h0;      // axi okay
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;      // axi slave error
    localparam int unsigned CLK_PERIOD_NS = 50;        // aclk period
    localparam int unsigned PLL_LOCK_TIME_NS = 1000;   // least lock time
    localparam int unsigned PLL_LOCK_CYCLES =
        (PLL_LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // power modes, one-hot
    typedef enum logic [2:0] {
        MODE_SHUTDOWN = 3'h1,
        MODE_STANDBY  = 3'h2,
        MODE_ACTIVE   = 3'h4
    } mode_t;

    // bits each lane carries per word for the link-select levels
    function automatic logic [4:0] bits_per_lane(input logic lo, input logic hi);
        if (lo && hi) begin
            return 5'h0A;
        end else if (lo || hi) begin
            return 5'h0F;
        end
        return 5'h1E;
    endfunction : bits_per_lane

    // number of lanes in use, 1 to 3
    function automatic logic [1:0] lane_count(input logic lo, input logic hi);
        if (lo && hi) begin
            return 2'h3;
        end else if (lo || hi) begin
            return 2'h2;
        end
        return 2'h1;
    endfunction : lane_count
endpackage : pixser_pkg
`default_nettype wire

// ===== rtl/rgb_pixel_serializer_tx.sv
// pixel serializer transmitter: capture, word build, lane shifting, power modes
// assumes all pins synchronous to aclk and pixel periods of at least 30 aclk
`default_nettype none
module rgb_pixel_serializer_tx #(
    parameter logic [15:0] IDLE_TIMEOUT_RST = pixser_pkg::CTRL_TIMEOUT_RST,
    parameter int unsigned LOCK_CYCLES      = pixser_pkg::PLL_LOCK_CYCLES
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        pixel_clk,
    input  wire logic [23:0] pixel_data,
    input  wire logic        vertical_sync,
    input  wire logic        horizontal_sync,
    input  wire logic        pixel_valid,
    input  wire logic        capture_edge_select,
    input  wire logic        lane_count_sel_lo,
    input  wire logic        lane_count_sel_hi,
    input  wire logic        transmit_on,
    input  wire logic        swap,
    output logic             serial_lane_a,
    output logic             serial_lane_a_oe_n,
    output logic             serial_lane_b,
    output logic             serial_lane_b_oe_n,
    output logic             serial_lane_c,
    output logic             serial_lane_c_oe_n,
    output logic             fwd_clk,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    import pixser_pkg::*;

    // whole state of the block
    typedef struct packed {
        mode_t       mode;      // power mode
        logic        pclk_d;    // pixel clock one cycle ago
        logic [7:0]  lock_cnt;  // pll lock progress
        logic [15:0] idle_cnt;  // cycles since last selected capture edge
        logic [15:0] timeout;   // software idle limit
        logic [29:0] shreg;     // word being sent
        logic [4:0]  bit_idx;   // bit slot within lane
        logic        busy;      // word on the lanes
        logic        lane_a;    // lane outputs
        logic        lane_b;
        logic        lane_c;
        logic        oe_a_n;    // lane enables, low drives
        logic        oe_b_n;
        logic        oe_c_n;
        logic        fclk;      // forwarded clock
        logic [31:0] words;     // words sent
        logic        awready;   // axi write side
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;   // axi read side
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
    } state_t;

    state_t st_r;   // registered state
    state_t st_nxt; // next state

    // build the 30-bit word from the pins
    function automatic logic [29:0] build_word(input logic [23:0] d, input logic sw,
                                               input logic vs, input logic hs,
                                               input logic de);
        logic [29:0] w;
        w = '0;
        for (int i = 0; i < COLOUR_BITS; i++) begin
            w[i] = sw ? d[COLOUR_BITS-1-i] : d[i];
        end
        w[POS_VS] = vs;
        w[POS_HS] = hs;
        w[POS_DE] = de;
        w[POS_PARITY] = ~^w[POS_DE:0];
        w[POS_RSV +: 2] = 2'h0;
        return w;
    endfunction : build_word

    // bit of the word at a slot, zero past the end
    function automatic logic pick(input logic [29:0] w, input logic [5:0] idx);
        return (idx < 6'(WORD_BITS)) ? w[idx[4:0]] : 1'b0;
    endfunction : pick

    logic [4:0] n_bits;   // bits per lane
    logic       rise;     // rising pixel edge
    logic       fall;     // falling pixel edge
    logic       sel_edge; // selected capture edge
    logic       locked;   // pll lock reached
    logic       load;     // word captured this cycle

    // edge, lane and lock decode
    always_comb begin
        n_bits   = bits_per_lane(lane_count_sel_lo, lane_count_sel_hi);
        rise     = pixel_clk && !st_r.pclk_d;
        fall     = !pixel_clk && st_r.pclk_d;
        sel_edge = capture_edge_select ? fall : rise;
        locked   = (st_r.lock_cnt == 8'(LOCK_CYCLES));
        load     = (st_r.mode == MODE_ACTIVE) && transmit_on && locked && sel_edge;
    end

    // next-state logic
    always_comb begin
        st_nxt = st_r;
        st_nxt.pclk_d = pixel_clk;
        // power mode sequencing
        case (st_r.mode)
            MODE_SHUTDOWN: begin
                if (transmit_on) begin
                    st_nxt.mode = MODE_STANDBY;
                end
            end
            MODE_STANDBY: begin
                if (sel_edge) begin
                    st_nxt.mode     = MODE_ACTIVE;   // pixel clock back
                    st_nxt.lock_cnt = 8'h00;
                    st_nxt.idle_cnt = 16'h0000;
                end
            end
            MODE_ACTIVE: begin
                if (!locked) begin
                    st_nxt.lock_cnt = st_r.lock_cnt + 8'h01;
                end
                if (sel_edge) begin
                    st_nxt.idle_cnt = 16'h0000;
                end else if (st_r.idle_cnt >= st_r.timeout) begin
                    st_nxt.mode = MODE_STANDBY;
                    st_nxt.busy = 1'b0;
                end else begin
                    st_nxt.idle_cnt = st_r.idle_cnt + 16'h0001;
                end
            end
            default: begin
                st_nxt.mode = MODE_SHUTDOWN;
            end
        endcase
        if (!transmit_on) begin
            st_nxt.mode = MODE_SHUTDOWN;
            st_nxt.busy = 1'b0;
        end
        // shifting at line rate, one bit per aclk per lane
        if (load) begin
            st_nxt.shreg   = build_word(pixel_data, swap, vertical_sync,
                                        horizontal_sync, pixel_valid);
            st_nxt.bit_idx = 5'h00;
            st_nxt.busy    = 1'b1;
            st_nxt.words   = st_r.words + 32'h1;
        end else if (st_r.busy && (st_r.mode == MODE_ACTIVE)) begin
            if (st_r.bit_idx == n_bits - 5'h01) begin
                st_nxt.busy = 1'b0;
            end else begin
                st_nxt.bit_idx = st_r.bit_idx + 5'h01;
            end
        end
        // lane data, consecutive slices of the word per lane
        st_nxt.lane_a = st_r.busy && pick(st_r.shreg, {1'b0, st_r.bit_idx});
        st_nxt.lane_b = st_r.busy && pick(st_r.shreg,
                                          6'(n_bits) + 6'(st_r.bit_idx));
        // lane c only with three lanes: for 30-bit lanes 2n plus the slot wraps six bits
        st_nxt.lane_c = st_r.busy && lane_count_sel_lo && lane_count_sel_hi &&
                        pick(st_r.shreg, 6'({n_bits, 1'b0}) + 6'(st_r.bit_idx));
        st_nxt.fclk   = st_r.busy && (st_r.bit_idx < (n_bits >> 1));
        // lane drive enables, quiet outside active
        st_nxt.oe_a_n = (st_r.mode != MODE_ACTIVE);
        st_nxt.oe_b_n = (st_r.mode != MODE_ACTIVE) ||
                        !(lane_count_sel_lo || lane_count_sel_hi);
        st_nxt.oe_c_n = (st_r.mode != MODE_ACTIVE) ||
                        !(lane_count_sel_lo && lane_count_sel_hi);
        // axi write: accept address and data together, then respond
        if (st_r.awready) begin
            st_nxt.awready = 1'b0;
            st_nxt.wready  = 1'b0;
            st_nxt.bvalid  = 1'b1;
            st_nxt.bresp   = RESP_SLVERR;
            if (s_axi_awaddr == OFS_CTRL) begin
                st_nxt.bresp = RESP_OKAY;
                if (s_axi_wstrb[0]) begin
                    st_nxt.timeout[7:0] = s_axi_wdata[7:0];
                end
                if (s_axi_wstrb[1]) begin
                    st_nxt.timeout[15:8] = s_axi_wdata[15:8];
                end
            end else if (s_axi_awaddr == OFS_STATUS || s_axi_awaddr == OFS_WORDS) begin
                st_nxt.bresp = RESP_OKAY;       // read-only, write ignored
            end
        end else if (st_r.bvalid) begin
            if (s_axi_bready) begin
                st_nxt.bvalid = 1'b0;
            end
        end else if (s_axi_awvalid && s_axi_wvalid) begin
            st_nxt.awready = 1'b1;
            st_nxt.wready  = 1'b1;
        end
        // axi read: one cycle of arready, data the cycle after
        if (st_r.arready) begin
            st_nxt.arready = 1'b0;
            st_nxt.rvalid  = 1'b1;
            st_nxt.rresp   = RESP_OKAY;
            st_nxt.rdata   = 32'h0;
            case (s_axi_araddr)
                OFS_CTRL:   st_nxt.rdata[15:0] = st_r.timeout;
                OFS_STATUS: begin
                    st_nxt.rdata[2:0] = st_r.mode;
                    st_nxt.rdata[STAT_LANES_LSB +: 2] =
                        lane_count(lane_count_sel_lo, lane_count_sel_hi);
                    st_nxt.rdata[STAT_LOCK_BIT] = locked;
                end
                OFS_WORDS:  st_nxt.rdata = st_r.words;
                default:    st_nxt.rresp = RESP_SLVERR;
            endcase
        end else if (st_r.rvalid) begin
            if (s_axi_rready) begin
                st_nxt.rvalid = 1'b0;
            end
        end else if (s_axi_arvalid) begin
            st_nxt.arready = 1'b1;
        end
    end

    // state register with synchronous reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r         <= '0;
            st_r.mode    <= MODE_SHUTDOWN;
            st_r.timeout <= IDLE_TIMEOUT_RST;
            st_r.oe_a_n  <= 1'b1;
            st_r.oe_b_n  <= 1'b1;
            st_r.oe_c_n  <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state register
    assign serial_lane_a      = st_r.lane_a;
    assign serial_lane_a_oe_n = st_r.oe_a_n;
    assign serial_lane_b      = st_r.lane_b;
    assign serial_lane_b_oe_n = st_r.oe_b_n;
    assign serial_lane_c      = st_r.lane_c;
    assign serial_lane_c_oe_n = st_r.oe_c_n;
    assign fwd_clk            = st_r.fclk;
    assign s_axi_awready      = st_r.awready;
    assign s_axi_wready       = st_r.wready;
    assign s_axi_bvalid       = st_r.bvalid;
    assign s_axi_bresp        = st_r.bresp;
    assign s_axi_arready      = st_r.arready;
    assign s_axi_rvalid       = st_r.rvalid;
    assign s_axi_rresp        = st_r.rresp;
    assign s_axi_rdata        = st_r.rdata;

    // captured word matches the pins of the capture cycle
    AST_CAPTURE: assert property (@(posedge aclk) disable iff (!aresetn)
        load |=> st_r.shreg == build_word($past(pixel_data), $past(swap),
            $past(vertical_sync), $past(horizontal_sync), $past(pixel_valid)))
        else $error("captured word differs from inputs");
    AST_PARITY: assert property (@(posedge aclk) disable iff (!aresetn)
        st_r.busy |-> (^st_r.shreg[POS_PARITY:0]) == 1'b1)
        else $error("word parity is not odd");
    AST_RESERVED: assert property (@(posedge aclk) disable iff (!aresetn)
        st_r.busy |-> st_r.shreg[POS_RSV +: 2] == 2'h0)
        else $error("reserved bits not low");
    AST_LANE_B_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
        (!lane_count_sel_lo && !lane_count_sel_hi) |=> serial_lane_b_oe_n)
        else $error("lane b driven with both selects low");
    AST_SHUTDOWN: assert property (@(posedge aclk) disable iff (!aresetn)
        !transmit_on |=> st_r.mode == MODE_SHUTDOWN && !st_r.busy)
        else $error("not in shutdown while transmit disabled");
    AST_STANDBY: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_r.mode == MODE_ACTIVE && transmit_on && !sel_edge &&
         st_r.idle_cnt >= st_r.timeout) |=> st_r.mode == MODE_STANDBY)
        else $error("idle pixel clock did not give standby");
    AST_QUIET: assert property (@(posedge aclk) disable iff (!aresetn)
        st_r.mode != MODE_ACTIVE |=> serial_lane_a_oe_n && !st_r.busy || $past(load))
        else $error("lane driven outside active mode");
    AST_BIT_STEP: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_r.busy && st_r.mode == MODE_ACTIVE && transmit_on && !load &&
         st_r.bit_idx != n_bits - 5'h01 && st_r.idle_cnt < st_r.timeout)
        |=> st_r.bit_idx == $past(st_r.bit_idx) + 5'h01)
        else $error("lane slot did not advance by one");
    AST_NO_LOAD_UNLOCKED: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(st_r.mode == MODE_ACTIVE) |-> !st_r.busy [*2])
        else $error("word sent before pll lock");
endmodule : rgb_pixel_serializer_tx
`default_nettype wire

// ===== test/pixel_link_rx.sv
// deserializer model on the far side: rebuilds 30-bit words from the lanes
// assumes lanes and forwarded clock change on aclk, one slot per aclk cycle
`default_nettype none
module pixel_link_rx (
    input  wire logic   aclk,
    input  wire logic   aresetn,
    input  wire logic   sel_lo,
    input  wire logic   sel_hi,
    input  wire logic   lane_a,
    input  wire logic   lane_b,
    input  wire logic   lane_c,
    input  wire logic   fwd_clk,
    output logic [29:0] word,
    output int          count
);
    timeunit 1ns;
    timeprecision 1ns;
    int          k;     // slot index in the current word
    int          n;     // slots per lane
    logic        fwd_q; // forwarded clock one sample ago
    logic [29:0] acc;   // word under assembly

    // a rising forwarded clock marks slot 0; lane b and c hold the upper slices
    always @(posedge aclk) begin
        n = (sel_lo && sel_hi) ? 10 : ((sel_lo || sel_hi) ? 15 : 30);
        if (!aresetn) begin
            k = 30;
            fwd_q = 1'b0;
            count = 0;
            word = '0;
        end else begin
            if (fwd_clk && !fwd_q) begin
                k = 0;
            end
            fwd_q = fwd_clk;
            if (k < n) begin
                acc[k] = lane_a;
                if (n <= 15) begin
                    acc[n + k] = lane_b;
                end
                if (n == 10) begin
                    acc[2 * n + k] = lane_c;
                end
                k++;
                if (k == n) begin
                    word = acc;
                    count++;
                end
            end
        end
    end
endmodule : pixel_link_rx
`default_nettype wire

// ===== test/tb_top.sv
// self-checking bench: register bus, power modes and lane words per lane setup
// assumes the design package and the deserializer model pixel_link_rx
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
    $display("BAD %s exp %h got %h", nm, e, g); fails++; end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import pixser_pkg::*;
    localparam logic [15:0] TMO = 16'h0060;  // idle timeout at reset
    localparam logic [3:0]  CFGS [4] = '{4'b0000, 4'b1011, 4'b0101, 4'b1110}; // lo,hi,edge,swap
    logic        aclk, aresetn, pixel_clk, vertical_sync, horizontal_sync, pixel_valid;
    logic        capture_edge_select, lane_count_sel_lo, lane_count_sel_hi, transmit_on, swap;
    logic [23:0] pixel_data;
    logic        serial_lane_a, serial_lane_a_oe_n, serial_lane_b, serial_lane_b_oe_n;
    logic        serial_lane_c, serial_lane_c_oe_n, fwd_clk;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int          fails, n_compared, rx_cnt;  // verdict counters, words rebuilt
    logic [29:0] rx_word;                    // last rebuilt word
    logic [29:0] exp_q [$];                  // words still expected
    // lane wires float when their driver is off
    wire lane_a_w = serial_lane_a_oe_n ? 1'bz : serial_lane_a;
    wire lane_b_w = serial_lane_b_oe_n ? 1'bz : serial_lane_b;
    wire lane_c_w = serial_lane_c_oe_n ? 1'bz : serial_lane_c;

    rgb_pixel_serializer_tx #(.IDLE_TIMEOUT_RST(TMO), .LOCK_CYCLES(2)) dut (
        .aclk, .aresetn, .pixel_clk, .pixel_data, .vertical_sync, .horizontal_sync,
        .pixel_valid, .capture_edge_select, .lane_count_sel_lo, .lane_count_sel_hi,
        .transmit_on, .swap, .serial_lane_a, .serial_lane_a_oe_n, .serial_lane_b,
        .serial_lane_b_oe_n, .serial_lane_c, .serial_lane_c_oe_n, .fwd_clk,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    pixel_link_rx rx (.aclk, .aresetn, .sel_lo(lane_count_sel_lo),
        .sel_hi(lane_count_sel_hi), .lane_a(lane_a_w), .lane_b(lane_b_w),
        .lane_c(lane_c_w), .fwd_clk, .word(rx_word), .count(rx_cnt));

    // 50 ns system clock
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    task automatic finish_test;
        if (fails == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test

    // a bound that ran out ends the run as a failure
    task automatic timed_out(input int i, input int lim);
        if (i >= lim) begin
            $display("BAD wait exp %h got %h", lim, i);
            fails++;
            finish_test();
        end
    endtask : timed_out

    task automatic cyc(input int c);
        repeat (c) @(posedge aclk);
    endtask : cyc

    // write: address and data offered together, each dropped when taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int i;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        timed_out(i, 50);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask : axi_wr

    // read: address held until taken, data taken at the rvalid edge
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int i;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        timed_out(i, 50);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : axi_rd

    // one pixel period of n slots, the selected edge last with new data
    task automatic pix(input int n, input logic [26:0] v);
        cyc(n / 2);
        pixel_clk <= capture_edge_select;
        cyc(n - n / 2);
        pixel_clk <= ~capture_edge_select;
        {pixel_valid, horizontal_sync, vertical_sync, pixel_data} <= v;
    endtask : pix

    // word as the lanes should carry it: colours, syncs, parity, zero tail
    function automatic logic [29:0] exp_word(input logic [26:0] v, input logic sw);
        logic [29:0] w;
        w = {3'b000, v};
        if (sw) for (int i = 0; i < 24; i++) w[i] = v[23 - i];
        w[27] = ~^w[26:0];
        return w;
    endfunction : exp_word

    // every rebuilt word must match the oldest pending pixel
    always @(rx_cnt) begin
        logic [29:0] e;
        e = (exp_q.size() > 0) ? exp_q.pop_front() : 30'bx;
        if (rx_cnt != 0) `CHK("word", e, rx_word)
    end

    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        logic [3:0]  cfg;
        logic [26:0] v;
        int          n, lanes, words, i, p, k;
        {pixel_clk, pixel_data, vertical_sync, horizontal_sync, pixel_valid} = '0;
        {capture_edge_select, lane_count_sel_lo, lane_count_sel_hi, transmit_on, swap} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        {fails, n_compared, words} = '0;
        aresetn = 1'b0;
        cyc(2);
        aresetn <= 1'b1;
        axi_rd(OFS_CTRL, d, r);
        `CHK("ctrl_rst", {16'h0, TMO}, d)
        axi_rd(OFS_STATUS, d, r);
        `CHK("status_rst", {1'b0, 2'b01, MODE_SHUTDOWN}, d[5:0])
        axi_wr(OFS_CTRL, 32'hFFFF_0050, r);
        axi_rd(OFS_CTRL, d, r);
        `CHK("ctrl_rw", 32'h0000_0050, d)
        s_axi_wstrb <= 4'h2;
        axi_wr(OFS_CTRL, 32'h0000_3377, r);
        axi_rd(OFS_CTRL, d, r);
        `CHK("ctrl_strb_hi", 32'h0000_3350, d)
        axi_wr(OFS_CTRL, 32'h0000_00EE, r);
        s_axi_wstrb <= 4'hF;
        axi_rd(OFS_CTRL, d, r);
        `CHK("ctrl_strb_back", 32'h0000_0050, d)
        axi_wr(OFS_STATUS, 32'hFFFF_FFFF, r);
        `CHK("status_wr_resp", RESP_OKAY, r)
        axi_rd(OFS_STATUS, d, r);
        `CHK("status_ro", {1'b0, 2'b01, MODE_SHUTDOWN}, d[5:0])
        axi_wr(8'h0C, 32'h1234_5678, r);
        `CHK("unmapped_wr", RESP_SLVERR, r)
        axi_rd(8'h0C, d, r);
        `CHK("unmapped_rd", {RESP_SLVERR, 32'h0}, {r, d})
        for (i = 0; i < 4; i++) begin
            cfg = CFGS[i];
            {lane_count_sel_lo, lane_count_sel_hi, capture_edge_select, swap} <= cfg;
            pixel_clk <= cfg[1];
            lanes = cfg[3] + cfg[2] + 1;
            n = 30 / lanes;
            cyc(2);
            pix(n, 27'h1);
            cyc(n + 4);
            `CHK("rx_off", words, rx_cnt)
            `CHK("oe_off", 3'b111, {serial_lane_a_oe_n, serial_lane_b_oe_n, serial_lane_c_oe_n})
            transmit_on <= 1'b1;
            cyc(3);
            for (p = 0; p < 5; p++) begin
                v = {p[2:0], 24'h3C_A5_0F ^ (24'h11_2233 * p[23:0])};
                if (p > 0) exp_q.push_back(exp_word(v, cfg[0]));
                pix(n, v);
            end
            `CHK("oe_on", {1'b0, lanes < 2, lanes < 3}, {serial_lane_a_oe_n,
                serial_lane_b_oe_n, serial_lane_c_oe_n})
            for (k = 0; k < 200 && exp_q.size() > 0; k++) cyc(1);
            timed_out(k, 200);
            axi_rd(OFS_STATUS, d, r);
            `CHK("status_on", {1'b1, lanes[1:0], MODE_ACTIVE}, d[5:0])
            words += 4;
            axi_rd(OFS_WORDS, d, r);
            `CHK("words", words, d)
            for (k = 0; k < 40; k++) begin
                axi_rd(OFS_STATUS, d, r);
                if (d[2:0] === MODE_STANDBY) break;
            end
            timed_out(k, 40);
            `CHK("standby", MODE_STANDBY, d[2:0])
            transmit_on <= 1'b0;
            cyc(3);
            axi_rd(OFS_STATUS, d, r);
            `CHK("shutdown", MODE_SHUTDOWN, d[2:0])
        end
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
